// File: rtl/laser_cfg.svh
// Timing counts, register offsets and reset values of the laser enable logic.
`ifndef LASER_CFG_SVH
`define LASER_CFG_SVH

`define CLK_FREQ_KHZ         125000
`define RESTART_DELAY_MS     5000
`define RESTART_DELAY_CYCLES (`RESTART_DELAY_MS * `CLK_FREQ_KHZ)
`define DEBOUNCE_US          10
`define DEBOUNCE_CYCLES      (`DEBOUNCE_US * `CLK_FREQ_KHZ / 1000)
`define PWM_IDLE_US          400
`define PWM_IDLE_CYCLES      (`PWM_IDLE_US * `CLK_FREQ_KHZ / 1000)

`define ADDR_CTRL            8'h00
`define ADDR_STATUS          8'h04
`define ADDR_IRQ_STATUS      8'h08
`define ADDR_IRQ_MASK        8'h0C
`define ADDR_PWM_PERIOD      8'h10
`define ADDR_PWM_HIGH        8'h14

`define CTRL_KEYSW_BIT       0
`define CTRL_STOP_BIT        1
`define CTRL_RESET           2'h1
`define IRQ_MASK_RESET       4'h0

`define IRQ_ILK_DROP_BIT     0
`define IRQ_READY_BIT        1
`define IRQ_FAULT_BIT        2
`define IRQ_RF_DROP_BIT      3

`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// File: rtl/laser_pkg.sv
// Types shared by the laser enable logic.
package laser_pkg;
	typedef enum logic [1:0] {ST_STOPPED, ST_WAIT, ST_READY} arm_state_t;

	typedef struct packed {
		logic over_temp;
		logic shutter_switch;
		logic keyswitch;
		logic reset_req;
		logic shutter_req;
		logic interlock;
	} level_in_t;

	typedef struct packed {
		logic       keysw_model;
		logic       emission;
		logic       fault;
		logic       interlock;
		logic       rf_enable;
		logic       shutter_open;
		logic       ready;
		arm_state_t state;
	} status_t;
endpackage : laser_pkg

// File: rtl/input_filter.sv
// Two-flop synchroniser and debouncer for each level input.
`include "laser_cfg.svh"
module input_filter
	import laser_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic resetn,
	input  level_in_t raw,
	output level_in_t clean
);
	localparam int N = $bits(level_in_t);
	localparam logic [10:0] LAST = 11'(`DEBOUNCE_CYCLES - 1);

	logic [N-1:0] sync1;
	logic [N-1:0] sync2;
	logic [N-1:0] stable;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= raw;
			sync2 <= sync1;
		end
	end

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_bit
			logic [10:0] cnt;
			logic        bit_q;
			// A level is taken only after it has held for the whole window.
			always_ff @(posedge ref_clk or negedge resetn) begin
				if (!resetn) begin
					cnt   <= '0;
					bit_q <= 1'b0;
				end else if (sync2[i] == bit_q) begin
					cnt <= '0;
				end else if (cnt == LAST) begin
					cnt   <= '0;
					bit_q <= sync2[i];
				end else begin
					cnt <= cnt + 11'h001;
				end
			end
			assign stable[i] = bit_q;
		end
	endgenerate

	assign clean = level_in_t'(stable);
endmodule : input_filter

// File: rtl/delay_timer.sv
// One-shot delay counter; done rises CYCLES clocks after start.
module delay_timer #(
	parameter int unsigned CYCLES = 8
) (
	input  wire logic ref_clk,
	input  wire logic resetn,
	input  wire logic start,
	input  wire logic clear,
	output logic      done
);
	logic [29:0] cnt;
	logic        running;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cnt     <= '0;
			running <= 1'b0;
			done    <= 1'b0;
		end else if (clear) begin
			running <= 1'b0;
			done    <= 1'b0;
		end else if (start) begin
			cnt     <= '0;
			running <= 1'b1;
			done    <= 1'b0;
		end else if (running) begin
			if (cnt == 30'(CYCLES - 1)) begin
				running <= 1'b0;
				done    <= 1'b1;
			end else begin
				cnt <= cnt + 30'h00000001;
			end
		end
	end
endmodule : delay_timer

// File: rtl/laser_enable_interlock_logic.sv
// Enable and interlock logic of the laser user port with its register slave.
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`include "laser_cfg.svh"

// Functional notes
// - Interlock inactive keeps RF drive off.
// - Keyswitch units latch off until re-armed.
// - Restart after recovery waits five seconds.
// - Non-keyswitch units re-enable immediately on interlock.
// - Optical output follows command duty cycle.
// - No shutter request keeps RF drive off.
// - Keyswitch units wait five seconds after shutter.
// - Keyswitch units need request and switch open.
// - Withdrawn request or closed switch inhibits lasing.
// - RF drive needs ready and shutter open.
// - Active lamp closed only while emitting.
// - Held reset request disables; release raises ready.
// - Ready output closed only while enabled.
// - Fault output closed on over-temperature.
module laser_enable_interlock_logic
	import laser_pkg::*;
#(
	parameter int unsigned DELAY_CYCLES = `RESTART_DELAY_CYCLES,
	parameter int unsigned IDLE_CYCLES  = `PWM_IDLE_CYCLES
) (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        interlock_in,
	input  wire logic        shutter_req_in,
	input  wire logic        reset_req_in,
	input  wire logic        keyswitch_in,
	input  wire logic        shutter_switch_in,
	input  wire logic        over_temp_in,
	input  wire logic        pwm_in,
	output logic             rf_enable,
	output logic             rf_pwm,
	output logic             emission_lamp,
	output logic             ready_out,
	output logic             shutter_lamp,
	output logic             temperature_lamp,
	output logic             interlock_open,
	output logic             irq
);
	level_in_t  raw;
	level_in_t  lvl;
	level_in_t  lvl_d;
	arm_state_t state;
	arm_state_t next_state;
	status_t    status;
	logic [1:0]  ctrl;
	logic [3:0]  irq_status;
	logic [3:0]  irq_mask;
	logic [15:0] per_cnt;
	logic [15:0] hi_cnt;
	logic [15:0] pwm_period;
	logic [15:0] pwm_high;
	logic        pwm_s1;
	logic        pwm_s2;
	logic        pwm_d;
	logic        restart_done;
	logic        shut_done;
	logic [11:0] warm_cnt;
	// Filter outputs start low, so a switch already on at power-up is not an arm action.
	wire         warm = (warm_cnt == 12'(`DEBOUNCE_CYCLES + 8));

	assign raw = '{over_temp: over_temp_in, shutter_switch: shutter_switch_in,
		keyswitch: keyswitch_in, reset_req: reset_req_in,
		shutter_req: shutter_req_in, interlock: interlock_in};

	input_filter u_filter (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.raw     (raw),
		.clean   (lvl)
	);

	// The command is too fast to debounce, so it is only synchronised.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pwm_s1 <= 1'b0;
			pwm_s2 <= 1'b0;
			pwm_d  <= 1'b0;
			lvl_d  <= '0;
			warm_cnt <= '0;
		end else begin
			pwm_s1 <= pwm_in;
			pwm_s2 <= pwm_s1;
			pwm_d  <= pwm_s2;
			lvl_d  <= lvl;
			warm_cnt <= warm_cnt + {11'h000, ~warm};
		end
	end

	wire keysw_model   = ctrl[`CTRL_KEYSW_BIT];
	wire sw_stop       = ctrl[`CTRL_STOP_BIT];
	wire keysw_on      = lvl.keyswitch & ~lvl_d.keyswitch;
	wire reset_release = ~lvl.reset_req & lvl_d.reset_req;
	wire arm_event     = (keysw_on | reset_release) & warm;
	wire shutter_rise  = lvl.shutter_req & ~lvl_d.shutter_req;
	wire ilk_drop      = ~lvl.interlock & lvl_d.interlock;
	wire pwm_rise      = pwm_s2 & ~pwm_d;

	// Any of these drops a keyswitch unit back to stopped; interlock
	// alone does not latch on the other model.
	wire hold_off = lvl.reset_req | sw_stop | lvl.over_temp
		| (keysw_model & (~lvl.keyswitch | ~lvl.interlock));

	always_comb begin
		next_state = state;
		if (hold_off) begin
			next_state = ST_STOPPED;
		end else begin
			case (state)
				ST_STOPPED: begin
					if (arm_event && lvl.interlock) begin
						next_state = keysw_model ? ST_WAIT : ST_READY;
					end
				end
				ST_WAIT: begin
					if (restart_done) begin
						next_state = ST_READY;
					end
				end
				ST_READY: next_state = ST_READY;
				default:  next_state = ST_STOPPED;
			endcase
		end
	end

	wire wait_start = (next_state == ST_WAIT) && (state != ST_WAIT);

	delay_timer #(
		.CYCLES (DELAY_CYCLES)
	) u_restart (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.start   (wait_start),
		.clear   (hold_off),
		.done    (restart_done)
	);

	delay_timer #(
		.CYCLES (DELAY_CYCLES)
	) u_shutter (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.start   (shutter_rise),
		.clear   (~lvl.shutter_req),
		.done    (shut_done)
	);

	wire shut_delay_ok = ~keysw_model | shut_done;
	wire shutter_now   = lvl.shutter_req & (~keysw_model | lvl.shutter_switch);
	wire ready_now     = (state == ST_READY) & lvl.interlock & ~lvl.reset_req
		& ~sw_stop & ~lvl.over_temp;
	wire next_rf       = ready_now & shutter_now & shut_delay_ok;
	wire pwm_active    = per_cnt < 16'(IDLE_CYCLES);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state            <= ST_STOPPED;
			rf_enable        <= 1'b0;
			rf_pwm           <= 1'b0;
			emission_lamp    <= 1'b0;
			ready_out        <= 1'b0;
			shutter_lamp     <= 1'b0;
			temperature_lamp <= 1'b0;
			interlock_open   <= 1'b0;
		end else begin
			state            <= next_state;
			rf_enable        <= next_rf;
			rf_pwm           <= next_rf & pwm_s2;
			emission_lamp    <= next_rf & pwm_active;
			ready_out        <= ready_now;
			shutter_lamp     <= shutter_now;
			temperature_lamp <= lvl.over_temp;
			interlock_open   <= ~lvl.interlock;
		end
	end

	// Duty measurement; counters saturate so an idle line reads as idle.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			per_cnt    <= 16'hFFFF;
			hi_cnt     <= '0;
			pwm_period <= '0;
			pwm_high   <= '0;
		end else if (pwm_rise) begin
			pwm_period <= per_cnt;
			pwm_high   <= hi_cnt;
			per_cnt    <= 16'h0001;
			hi_cnt     <= 16'h0001;
		end else begin
			if (per_cnt != 16'hFFFF) begin
				per_cnt <= per_cnt + 16'h0001;
			end
			if (pwm_s2 && hi_cnt != 16'hFFFF) begin
				hi_cnt <= hi_cnt + 16'h0001;
			end
		end
	end

	// Register slave: address and data may come in either order.
	logic        aw_got;
	logic        w_got;
	logic [7:0]  aw_addr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;

	assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_got & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	wire aw_fire = s_axi_awvalid & s_axi_awready;
	wire w_fire  = s_axi_wvalid & s_axi_wready;
	wire ar_fire = s_axi_arvalid & s_axi_arready;
	wire wr_go   = aw_got & w_got;

	wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	wire [31:0] wbits = wdata_q & wmask;
	wire wr_ctrl  = wr_go & (aw_addr_q == `ADDR_CTRL);
	wire wr_istat = wr_go & (aw_addr_q == `ADDR_IRQ_STATUS);
	wire wr_imask = wr_go & (aw_addr_q == `ADDR_IRQ_MASK);
	wire wr_ro    = (aw_addr_q == `ADDR_STATUS) | (aw_addr_q == `ADDR_PWM_PERIOD)
		| (aw_addr_q == `ADDR_PWM_HIGH);
	wire wr_hit   = (aw_addr_q == `ADDR_CTRL) | (aw_addr_q == `ADDR_IRQ_STATUS)
		| (aw_addr_q == `ADDR_IRQ_MASK) | wr_ro;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			aw_got       <= 1'b0;
			w_got        <= 1'b0;
			aw_addr_q    <= '0;
			wdata_q      <= '0;
			wstrb_q      <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else begin
			if (aw_fire) begin
				aw_got    <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (w_fire) begin
				w_got   <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_got       <= 1'b0;
				w_got        <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	assign status = '{keysw_model: keysw_model, emission: emission_lamp,
		fault: temperature_lamp, interlock: lvl.interlock, rf_enable: rf_enable,
		shutter_open: shutter_lamp, ready: ready_out, state: state};

	wire rd_hit = (s_axi_araddr == `ADDR_CTRL) | (s_axi_araddr == `ADDR_STATUS)
		| (s_axi_araddr == `ADDR_IRQ_STATUS) | (s_axi_araddr == `ADDR_IRQ_MASK)
		| (s_axi_araddr == `ADDR_PWM_PERIOD) | (s_axi_araddr == `ADDR_PWM_HIGH);
	wire [31:0] rd_word =
		(s_axi_araddr == `ADDR_CTRL)       ? {30'h0, ctrl} :
		(s_axi_araddr == `ADDR_STATUS)     ? {23'h0, status} :
		(s_axi_araddr == `ADDR_IRQ_STATUS) ? {28'h0, irq_status} :
		(s_axi_araddr == `ADDR_IRQ_MASK)   ? {28'h0, irq_mask} :
		(s_axi_araddr == `ADDR_PWM_PERIOD) ? {16'h0, pwm_period} :
		(s_axi_araddr == `ADDR_PWM_HIGH)   ? {16'h0, pwm_high} : 32'h0;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (ar_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// A new event in the clearing cycle survives the write-one-to-clear.
	wire [3:0] irq_event;
	assign irq_event[`IRQ_ILK_DROP_BIT] = ilk_drop;
	assign irq_event[`IRQ_READY_BIT]    = ready_now & ~ready_out;
	assign irq_event[`IRQ_FAULT_BIT]    = lvl.over_temp & ~temperature_lamp;
	assign irq_event[`IRQ_RF_DROP_BIT]  = ~next_rf & rf_enable;
	wire [3:0] irq_clear = wr_istat ? wbits[3:0] : 4'h0;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl       <= `CTRL_RESET;
			irq_mask   <= `IRQ_MASK_RESET;
			irq_status <= '0;
			irq        <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl <= (ctrl & ~wmask[1:0]) | wbits[1:0];
			end
			if (wr_imask) begin
				irq_mask <= (irq_mask & ~wmask[3:0]) | wbits[3:0];
			end
			irq_status <= (irq_status & ~irq_clear) | irq_event;
			irq        <= |(irq_status & irq_mask);
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	rf_off_ilk_a: assert property (!lvl.interlock |=> !rf_enable)
		else $error("RF drive on without interlock");
	ks_relatch_a: assert property (keysw_model && ilk_drop |=> state == ST_STOPPED)
		else $error("Keyswitch unit not latched off after interlock drop");
	wait_inhibit_a: assert property (state == ST_WAIT |=> !rf_enable)
		else $error("RF drive on during restart wait");
	oem_now_a: assert property (!keysw_model && state == ST_READY && $rose(lvl.interlock)
		&& !lvl.reset_req && !sw_stop && !lvl.over_temp |=> ready_out)
		else $error("Interlock return did not re-enable at once");
	rf_shut_a: assert property (!lvl.shutter_req |=> !rf_enable)
		else $error("RF drive on without shutter request");
	shut_delay_a: assert property (keysw_model && shutter_rise |-> ##1 !rf_enable [*8])
		else $error("RF drive on inside shutter delay");
	switch_gate_a: assert property (keysw_model && !lvl.shutter_switch |=> !rf_enable)
		else $error("RF drive on with shutter switch closed");
	rf_pair_a: assert property (rf_enable |-> ready_out && shutter_lamp)
		else $error("RF drive on without ready and shutter");
	lamp_a: assert property (emission_lamp |-> rf_enable)
		else $error("Active lamp without RF drive");
	reset_hold_a: assert property (lvl.reset_req |=> !ready_out && !rf_enable)
		else $error("Enabled while reset request held");
	fault_lamp_a: assert property (lvl.over_temp |=> temperature_lamp && !rf_enable)
		else $error("Fault not shown or RF drive on");
	no_arm_a: assert property (state == ST_STOPPED && !arm_event |=> state == ST_STOPPED)
		else $error("Left stopped without arm action");

	ready_c: cover property (state == ST_WAIT ##1 state == ST_READY);
	rf_on_c: cover property ($rose(rf_enable));
	irq_c:   cover property ($rose(irq));
endmodule : laser_enable_interlock_logic

// File: verif/controller_model.sv
// Machine controller model that drives the laser's level inputs and power command.
module controller_model
	import laser_pkg::*;
#(
	parameter int unsigned PERIOD_CYCLES = 800,
	parameter int unsigned SETTLE_CYCLES = 200
) (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  level_in_t        cmd,
	input  wire logic [15:0] duty_high,
	output level_in_t        pins,
	output logic             pwm_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] phase;
	logic [15:0] settle;
	wire         settled = (settle >= SETTLE_CYCLES[15:0]);

	// A period of 800 cycles is about 156 kHz, just inside the highest allowed rate.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			phase   <= 16'h0000;
			settle  <= 16'h0000;
			pins    <= '0;
			pwm_out <= 1'h0;
		end else begin
			phase   <= (phase == PERIOD_CYCLES[15:0] - 16'h0001) ? 16'h0000 : phase + 16'h0001;
			pwm_out <= (phase < duty_high);
			if (!settled) begin
				settle <= settle + 16'h0001;
			end
			pins           <= cmd;
			pins.reset_req <= cmd.reset_req & settled;
		end
	end
endmodule : controller_model

// File: verif/laser_enable_interlock_logic_bench.sv
// Self-checking bench for the laser enable and interlock logic.
`include "laser_cfg.svh"
module laser_enable_interlock_logic_bench
	import laser_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DLY = 400;
	localparam int SET = 1300;
	localparam int PER = 800;
	localparam int ILK = 0;
	localparam int SHUT = 1;
	localparam int RST = 2;
	localparam int KEY = 3;
	localparam int SW = 4;
	localparam int HOT = 5;
	logic        ref_clk, resetn;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic        pwm_in, rf_enable, rf_pwm, emission_lamp, ready_out;
	logic        shutter_lamp, temperature_lamp, interlock_open, irq;
	level_in_t   cmd, pins;
	logic [15:0] duty;
	logic [15:0] duty_tab [2] = '{16'h0190, 16'h02F8};
	int          failures, samples_checked, hi;

	controller_model #(.PERIOD_CYCLES(PER), .SETTLE_CYCLES(200)) partner (
		.ref_clk(ref_clk), .resetn(resetn), .cmd(cmd), .duty_high(duty),
		.pins(pins), .pwm_out(pwm_in));

	laser_enable_interlock_logic #(.DELAY_CYCLES(DLY), .IDLE_CYCLES(1000)) dut (
		.ref_clk(ref_clk), .resetn(resetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.interlock_in(pins.interlock), .shutter_req_in(pins.shutter_req),
		.reset_req_in(pins.reset_req), .keyswitch_in(pins.keyswitch),
		.shutter_switch_in(pins.shutter_switch), .over_temp_in(pins.over_temp),
		.pwm_in(pwm_in), .rf_enable(rf_enable), .rf_pwm(rf_pwm), .emission_lamp(emission_lamp),
		.ready_out(ready_out), .shutter_lamp(shutter_lamp), .temperature_lamp(temperature_lamp),
		.interlock_open(interlock_open), .irq(irq));

	initial begin
		ref_clk = 1'h0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic timeout(input string what);
		failures++;
		$display("[ERR] %s expected completion seen timeout", what);
		report_and_stop();
	endtask : timeout

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : wait_cyc

	task automatic set_pin(input int idx, input logic v);
		@(posedge ref_clk);
		cmd[idx] <= v;
	endtask : set_pin

	// Both write channels are offered together; each is released on its own handshake.
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int   n;
		logic ta, tw, tb;
		logic [1:0] r;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < 64; n++) begin
			@(negedge ref_clk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = s_axi_bvalid & s_axi_bready;
			r = s_axi_bresp;
			@(posedge ref_clk);
			if (ta) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
			if (tb) begin
				s_axi_bready <= 1'h0;
				break;
			end
		end
		if (n == 64) timeout("write");
		check("bresp", {30'h0, r}, {30'h0, er});
	endtask : axi_write

	task automatic reg_check(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
			input logic [1:0] er);
		int   n;
		logic ta, tr;
		logic [31:0] d;
		logic [1:0]  r;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < 64; n++) begin
			@(negedge ref_clk);
			ta = s_axi_arvalid & s_axi_arready;
			tr = s_axi_rvalid & s_axi_rready;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge ref_clk);
			if (ta) s_axi_arvalid <= 1'h0;
			if (tr) begin
				s_axi_rready <= 1'h0;
				break;
			end
		end
		if (n == 64) timeout("read");
		check("rdata", d & m, e);
		check("rresp", {30'h0, r}, {30'h0, er});
	endtask : reg_check

	task automatic state_is(input arm_state_t s);
		reg_check(`ADDR_STATUS, 32'h00000003, {30'h0, s}, `RESP_OKAY);
	endtask : state_is

	task automatic outs_are(input logic rf, input logic rdy);
		check("rf_enable", {31'h0, rf_enable}, {31'h0, rf});
		check("ready_out", {31'h0, ready_out}, {31'h0, rdy});
	endtask : outs_are

	initial begin
		repeat (90000) @(posedge ref_clk);
		timeout("run");
	end

	initial begin
		resetn = 1'h0;
		cmd = '0;
		duty = 16'h0190;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		failures = 0;
		samples_checked = 0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'h1;
		wait_cyc(1);
		outs_are(1'h0, 1'h0);
		reg_check(`ADDR_CTRL, 32'hFFFFFFFF, 32'h00000001, `RESP_OKAY);
		reg_check(`ADDR_IRQ_MASK, 32'hFFFFFFFF, 32'h00000000, `RESP_OKAY);
		reg_check(8'h40, 32'hFFFFFFFF, 32'h00000000, `RESP_SLVERR);
		axi_write(8'h40, 32'h00000001, `RESP_SLVERR);
		$display("Test reset values done");
		set_pin(ILK, 1'h1);
		set_pin(SHUT, 1'h1);
		set_pin(SW, 1'h1);
		wait_cyc(SET);
		state_is(ST_STOPPED);
		outs_are(1'h0, 1'h0);
		set_pin(KEY, 1'h1);
		wait_cyc(SET);
		state_is(ST_WAIT);
		outs_are(1'h0, 1'h0);
		wait_cyc(DLY + 50);
		outs_are(1'h1, 1'h1);
		check("shutter_lamp", {31'h0, shutter_lamp}, 32'h1);
		check("emission_lamp", {31'h0, emission_lamp}, 32'h1);
		for (int i = 0; i < 2; i++) begin
			@(posedge ref_clk);
			duty <= duty_tab[i];
			wait_cyc(2 * PER);
			hi = 0;
			repeat (PER) begin
				@(negedge ref_clk);
				hi += int'(rf_pwm);
			end
			check("rf_pwm high", hi, {16'h0, duty_tab[i]});
		end
		reg_check(`ADDR_PWM_PERIOD, 32'hFFFFFFFF, PER, `RESP_OKAY);
		reg_check(`ADDR_PWM_HIGH, 32'hFFFFFFFF, {16'h0, duty_tab[1]}, `RESP_OKAY);
		$display("Test keyswitch arm done");
		set_pin(SHUT, 1'h0);
		wait_cyc(SET);
		outs_are(1'h0, 1'h1);
		check("emission_lamp", {31'h0, emission_lamp}, 32'h0);
		set_pin(SHUT, 1'h1);
		wait_cyc(SET);
		check("rf_enable", {31'h0, rf_enable}, 32'h0);
		wait_cyc(DLY + 50);
		check("rf_enable", {31'h0, rf_enable}, 32'h1);
		set_pin(SW, 1'h0);
		wait_cyc(SET);
		check("rf_enable", {31'h0, rf_enable}, 32'h0);
		check("shutter_lamp", {31'h0, shutter_lamp}, 32'h0);
		set_pin(SW, 1'h1);
		wait_cyc(SET + DLY + 50);
		check("rf_enable", {31'h0, rf_enable}, 32'h1);
		$display("Test shutter done");
		set_pin(ILK, 1'h0);
		wait_cyc(SET);
		outs_are(1'h0, 1'h0);
		check("interlock_open", {31'h0, interlock_open}, 32'h1);
		reg_check(`ADDR_IRQ_STATUS, 32'h00000001, 32'h00000001, `RESP_OKAY);
		axi_write(`ADDR_IRQ_MASK, 32'h00000001, `RESP_OKAY);
		wait_cyc(2);
		check("irq", {31'h0, irq}, 32'h1);
		axi_write(`ADDR_IRQ_STATUS, 32'h00000001, `RESP_OKAY);
		wait_cyc(2);
		check("irq", {31'h0, irq}, 32'h0);
		set_pin(ILK, 1'h1);
		wait_cyc(SET + DLY + 50);
		state_is(ST_STOPPED);
		outs_are(1'h0, 1'h0);
		set_pin(RST, 1'h1);
		wait_cyc(SET);
		outs_are(1'h0, 1'h0);
		set_pin(RST, 1'h0);
		wait_cyc(SET);
		state_is(ST_WAIT);
		wait_cyc(DLY + 50);
		outs_are(1'h1, 1'h1);
		$display("Test interlock latch done");
		set_pin(HOT, 1'h1);
		wait_cyc(SET);
		check("temperature_lamp", {31'h0, temperature_lamp}, 32'h1);
		outs_are(1'h0, 1'h0);
		set_pin(HOT, 1'h0);
		wait_cyc(SET);
		check("temperature_lamp", {31'h0, temperature_lamp}, 32'h0);
		$display("Test fault done");
		axi_write(`ADDR_CTRL, 32'h00000000, `RESP_OKAY);
		set_pin(RST, 1'h1);
		wait_cyc(SET);
		set_pin(RST, 1'h0);
		wait_cyc(SET);
		outs_are(1'h1, 1'h1);
		set_pin(ILK, 1'h0);
		wait_cyc(SET);
		outs_are(1'h0, 1'h0);
		set_pin(ILK, 1'h1);
		wait_cyc(SET);
		outs_are(1'h1, 1'h1);
		axi_write(`ADDR_CTRL, 32'h00000002, `RESP_OKAY);
		wait_cyc(3);
		outs_are(1'h0, 1'h0);
		state_is(ST_STOPPED);
		reg_check(`ADDR_CTRL, 32'hFFFFFFFF, 32'h00000002, `RESP_OKAY);
		$display("Test unlatched interlock done");
		report_and_stop();
	end
endmodule : laser_enable_interlock_logic_bench
